// >>> src/pkh_top.sv
`timescale 1ns/100ps
// Operation
// - Each of channels 2 to 5 keeps the largest code seen since its last read.
// - Reading a peak byte returns it and then clears it to zero.
// - After reset every peak byte is zero until a conversion updates it.
// - A peak sits in two bytes, lower at the even address, upper odd.
// - Pairs for channels 2 to 5 run contiguously in ascending channel order.
module pkh_top
  import pkh_pkg::*;
(
  input  wire logic                   ref_clk_in,
  input  wire logic                   rst_n_in,
  input  wire logic                   conv_valid_in,
  input  wire logic [2:0]             conv_chan_in,
  input  wire logic [pkh_pkg::CODE_W-1:0] conv_code_in,
  input  wire logic [pkh_pkg::ADDR_W-1:0] reg_addr_in,
  input  wire logic                   reg_rd_in,
  input  wire logic                   reg_wr_in,
  input  wire logic [pkh_pkg::BYTE_W-1:0] reg_wdata_in,
  output logic      [pkh_pkg::BYTE_W-1:0] reg_rdata_out,
  output logic                        reg_rvalid_out
);
  // ==========================================================
  // Address decode
  logic [ADDR_W-1:0] rd_off;
  logic              rd_hit;
  logic [1:0]        rd_idx;
  logic              rd_high;
  logic [CODE_W-1:0] peak_w [NUM_CH];
  logic [BYTE_W-1:0] rd_byte;
  logic [BYTE_W-1:0] rdata_reg;
  logic              rvalid_reg;

  // Pairs are contiguous, so channel and byte come from the offset bits
  assign rd_off  = reg_addr_in - PEAK_BASE_ADDR;
  assign rd_hit  = (reg_addr_in >= PEAK_BASE_ADDR) &&
                   (reg_addr_in <= PEAK_LAST_ADDR);
  assign rd_idx  = rd_off[2:1];
  assign rd_high = rd_off[0];

  // ==========================================================
  // Per-channel trackers
  pkh_chan_if #(.CODE_W(CODE_W)) u_if [NUM_CH] ();

  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    localparam logic [2:0] CHAN_CODE = FIRST_CHAN_CODE + 3'(i);
    localparam logic [ADDR_W-1:0] LOW_ADDR =
      PEAK_BASE_ADDR + ADDR_W'(2 * i);
    localparam logic [ADDR_W-1:0] HIGH_ADDR = LOW_ADDR + 8'h01;
    logic seen_reg;

    // Only reads clear; the write strobe never reaches a tracker
    assign u_if[i].conv_valid = conv_valid_in &&
                                (conv_chan_in == CHAN_CODE);
    assign u_if[i].conv_code  = conv_code_in;
    assign u_if[i].clr_low    = reg_rd_in && rd_hit &&
                                (rd_idx == 2'(i)) && !rd_high;
    assign u_if[i].clr_high   = reg_rd_in && rd_hit &&
                                (rd_idx == 2'(i)) && rd_high;
    assign peak_w[i]          = u_if[i].peak;

    pkh_chan_track u_track (
      .ref_clk_in (ref_clk_in),
      .rst_n_in   (rst_n_in),
      .bus        (u_if[i].track)
    );

    // Helper: a conversion has touched this channel since reset
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        seen_reg <= 1'b0;
      end else if (u_if[i].conv_valid) begin
        seen_reg <= 1'b1;
      end
    end

    // ==========================================================
    // Checks
    sequence s_rd_low;
      reg_rd_in && (reg_addr_in == LOW_ADDR);
    endsequence

    sequence s_rd_high;
      reg_rd_in && (reg_addr_in == HIGH_ADDR);
    endsequence

    sequence s_quiet;
      !u_if[i].conv_valid && !u_if[i].clr_low && !u_if[i].clr_high;
    endsequence

    a_peak_keeps_max : assert property (
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      u_if[i].conv_valid && !u_if[i].clr_low && !u_if[i].clr_high
      |=> peak_w[i] == (($past(conv_code_in) > $past(peak_w[i])) ?
                        $past(conv_code_in) : $past(peak_w[i])))
      else $error("peak did not follow larger code");

    a_read_clears_low : assert property (
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      s_rd_low ##0 !u_if[i].conv_valid
      |=> peak_w[i][LOW_BYTE_LSB +: BYTE_W] == BYTE_ZERO)
      else $error("low byte not cleared by read");

    a_reset_zero : assert property (
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      !seen_reg |-> peak_w[i] == PEAK_RESET)
      else $error("peak nonzero before any conversion");

    a_map_low_byte : assert property (
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      s_rd_low |=> reg_rvalid_out &&
      reg_rdata_out == $past(peak_w[i][LOW_BYTE_LSB +: BYTE_W]))
      else $error("even address did not return lower byte");

    a_map_high_byte : assert property (
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      s_rd_high |=> reg_rvalid_out &&
      reg_rdata_out == $past(peak_w[i][HIGH_BYTE_LSB +: BYTE_W]))
      else $error("odd address did not return upper byte");

    a_write_ignored : assert property (
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      reg_wr_in ##0 s_quiet |=> $stable(peak_w[i]))
      else $error("write disturbed a peak register");

    a_read_clears_high : assert property (
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      s_rd_high ##0 !u_if[i].conv_valid
      |=> peak_w[i][HIGH_BYTE_LSB +: BYTE_W] == BYTE_ZERO)
      else $error("high byte not cleared by read");

    // Clear is per byte, so a read must leave the other half alone
    a_low_keeps_high : assert property (
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      s_rd_low ##0 !u_if[i].conv_valid
      |=> peak_w[i][HIGH_BYTE_LSB +: BYTE_W] ==
          $past(peak_w[i][HIGH_BYTE_LSB +: BYTE_W]))
      else $error("low byte read disturbed high byte");

    a_high_keeps_low : assert property (
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      s_rd_high ##0 !u_if[i].conv_valid
      |=> peak_w[i][LOW_BYTE_LSB +: BYTE_W] ==
          $past(peak_w[i][LOW_BYTE_LSB +: BYTE_W]))
      else $error("high byte read disturbed low byte");

    // A code racing a clear must never be lost to it
    a_code_beats_clear : assert property (
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      (u_if[i].clr_low || u_if[i].clr_high) && u_if[i].conv_valid
      |=> peak_w[i] >= $past(conv_code_in))
      else $error("code lost against a read clear");

    a_quiet_holds : assert property (
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      s_quiet |=> $stable(peak_w[i]))
      else $error("peak moved with no code and no read");
  end

  // ==========================================================
  // Read data path
  always_comb begin
    rd_byte = BYTE_ZERO;  // Unmapped addresses read as zero
    if (rd_hit) begin
      if (rd_high) begin
        rd_byte = peak_w[rd_idx][HIGH_BYTE_LSB +: BYTE_W];
      end else begin
        rd_byte = peak_w[rd_idx][LOW_BYTE_LSB +: BYTE_W];
      end
    end
  end

  // Byte captured before the clear lands in the same edge
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_reg <= BYTE_ZERO;
    end else if (reg_rd_in) begin
      rdata_reg <= rd_byte;
    end
  end

  // One-cycle pulse marking the answer to a read
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= reg_rd_in;
    end
  end

  // ==========================================================
  // Read port checks
  sequence s_rd_unmapped;
    reg_rd_in && !rd_hit;
  endsequence

  // Every read gets exactly one answer, one cycle later
  a_answer_pulse : assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    reg_rvalid_out == $past(reg_rd_in))
    else $error("answer pulse does not follow read strobe");

  // Addresses outside the pairs read as zero
  a_unmapped_zero : assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    s_rd_unmapped |=> reg_rdata_out == BYTE_ZERO)
    else $error("unmapped address returned nonzero data");

  // Read data stands until the next read
  a_rdata_holds : assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    !reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data changed without a read");

  // Write data has no destination: all registers here are read-only
  logic unused_wr;
  assign unused_wr = reg_wr_in ^ (^reg_wdata_in);

  assign reg_rdata_out  = rdata_reg;
  assign reg_rvalid_out = rvalid_reg;
endmodule // pkh_top

// >>> src/pkh_pkg.sv
package pkh_pkg;
  // ==========================================================
  // Geometry
  localparam int NUM_CH = 4;   // Channels 2 to 5 tracked here
  localparam int CODE_W = 16;  // Stored peak, one byte pair
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 8;
  localparam logic [2:0] FIRST_CHAN_CODE = 3'h2;

  // ==========================================================
  // Register map, ascending byte pairs, lower byte even
  localparam logic [ADDR_W-1:0] PEAK_CHAN2_LOWER_ADDR = 8'h64;
  localparam logic [ADDR_W-1:0] PEAK_CHAN2_UPPER_ADDR = 8'h65;
  localparam logic [ADDR_W-1:0] PEAK_CHAN3_LOWER_ADDR = 8'h66;
  localparam logic [ADDR_W-1:0] PEAK_CHAN3_UPPER_ADDR = 8'h67;
  localparam logic [ADDR_W-1:0] PEAK_CHAN4_LOWER_ADDR = 8'h68;
  localparam logic [ADDR_W-1:0] PEAK_CHAN4_UPPER_ADDR = 8'h69;
  localparam logic [ADDR_W-1:0] PEAK_CHAN5_LOWER_ADDR = 8'h6A;
  localparam logic [ADDR_W-1:0] PEAK_CHAN5_UPPER_ADDR = 8'h6B;
  localparam logic [ADDR_W-1:0] PEAK_BASE_ADDR = PEAK_CHAN2_LOWER_ADDR;
  localparam logic [ADDR_W-1:0] PEAK_LAST_ADDR = PEAK_CHAN5_UPPER_ADDR;

  // ==========================================================
  // Field layout and reset values
  localparam int LOW_BYTE_LSB  = 0;
  localparam int HIGH_BYTE_LSB = 8;
  localparam logic [CODE_W-1:0] PEAK_RESET = 16'h0000;
  localparam logic [BYTE_W-1:0] BYTE_ZERO  = 8'h00;
endpackage

// >>> src/pkh_chan_if.sv
`timescale 1ns/100ps
// ==========================================================
// Carrier between the register front end and one tracker
interface pkh_chan_if #(
  parameter int CODE_W = 16
);
  logic              conv_valid;
  logic [CODE_W-1:0] conv_code;
  logic              clr_low;
  logic              clr_high;
  logic [CODE_W-1:0] peak;

  modport ctrl  (output conv_valid, conv_code, clr_low, clr_high,
                 input  peak);
  modport track (input  conv_valid, conv_code, clr_low, clr_high,
                 output peak);
endinterface // pkh_chan_if

// >>> src/pkh_chan_track.sv
`timescale 1ns/100ps
// ==========================================================
// One channel peak tracker with per-byte clear on read
module pkh_chan_track
  import pkh_pkg::*;
(
  input  wire logic   ref_clk_in,
  input  wire logic   rst_n_in,
  pkh_chan_if.track   bus
);
  logic [CODE_W-1:0] peak_reg;
  logic [CODE_W-1:0] base;
  logic [CODE_W-1:0] peak_next;

  // Clear is applied first so a code arriving in the read cycle survives
  always_comb begin
    base = peak_reg;
    if (bus.clr_low) begin
      base[LOW_BYTE_LSB +: BYTE_W] = BYTE_ZERO;
    end
    if (bus.clr_high) begin
      base[HIGH_BYTE_LSB +: BYTE_W] = BYTE_ZERO;
    end
    if (bus.conv_valid && (bus.conv_code > base)) begin
      peak_next = bus.conv_code;
    end else begin
      peak_next = base;
    end
  end

  // Stored maximum, zero out of reset
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      peak_reg <= PEAK_RESET;
    end else begin
      peak_reg <= peak_next;
    end
  end

  assign bus.peak = peak_reg;
endmodule // pkh_chan_track

// >>> tb/pkh_top_bench.sv
`timescale 1ns/100ps
module pkh_top_bench;
  import pkh_pkg::*;
  // ==========================================================
  // Stimulus, model and expectation state
  logic              ref_clk_in, rst_n_in, conv_valid_in;
  logic              reg_rd_in, reg_wr_in, reg_rvalid_out;
  logic [2:0]        conv_chan_in;
  logic [CODE_W-1:0] conv_code_in;
  logic [ADDR_W-1:0] reg_addr_in;
  logic [BYTE_W-1:0] reg_wdata_in, reg_rdata_out;
  logic [CODE_W-1:0] pk [2:5];
  logic [BYTE_W-1:0] exp_q [$];
  logic [31:0]       seed = 32'h39;
  logic [31:0]       r1, r2;
  int                errors, samples_checked, cycles;

  pkh_top u_pkh_top (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .conv_valid_in(conv_valid_in), .conv_chan_in(conv_chan_in),
    .conv_code_in(conv_code_in), .reg_addr_in(reg_addr_in),
    .reg_rd_in(reg_rd_in), .reg_wr_in(reg_wr_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .reg_rvalid_out(reg_rvalid_out));

  // 40 MHz clock
  initial begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // One cycle of stimulus; the model clears a read byte before the
  // compare, so a code in the same cycle wins over the clear
  task automatic drv(input logic v, input logic [2:0] ch,
                     input logic [15:0] cd, input logic r, input logic w,
                     input logic [7:0] a, input logic [7:0] wd);
    logic [7:0] c;
    @(posedge ref_clk_in);
    conv_valid_in <= v;
    conv_chan_in  <= ch;
    conv_code_in  <= cd;
    reg_rd_in     <= r;
    reg_wr_in     <= w;
    reg_addr_in   <= a;
    reg_wdata_in  <= wd;
    if (r && a >= PEAK_BASE_ADDR && a <= PEAK_LAST_ADDR) begin
      c = 8'h02 + ((a - PEAK_BASE_ADDR) >> 1);
      exp_q.push_back(a[0] ? pk[c][15:8] : pk[c][7:0]);
      if (a[0]) pk[c][15:8] = BYTE_ZERO;
      else pk[c][7:0] = BYTE_ZERO;
    end else if (r) begin
      exp_q.push_back(BYTE_ZERO);
    end
    if (v && ch >= 3'h2 && ch <= 3'h5 && cd > pk[ch]) pk[ch] = cd;
  endtask

  // Reset with strobes idle; any answer in flight lands first
  task automatic rst();
    drv(0, 0, 0, 0, 0, 0, 0);
    @(posedge ref_clk_in);
    rst_n_in <= 1'b0;
    for (int i = 2; i <= 5; i++) pk[i] = PEAK_RESET;
    repeat (3) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
  endtask

  // Reads every peak byte plus one unmapped byte on each side
  task automatic sweep();
    for (int a = 'h63; a <= 'h6C; a++) drv(0, 0, 0, 1, 0, 8'(a), 0);
  endtask

  // Answers pop the oldest note; rvalid with nothing owed is an error
  always @(posedge ref_clk_in) begin
    if (reg_rvalid_out === 1'b1) begin
      if (exp_q.size() == 0) check(8'h01, 8'h00);
      else check(reg_rdata_out, exp_q.pop_front());
    end
  end

  // Hang guard, well above the roughly 2030 cycles the run needs
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 6000) begin
      errors++;
      tally_and_finish();
    end
  end

  // Main sequence: random traffic mixes codes for all channels,
  // ignored writes and reads over and around the map
  initial begin
    {rst_n_in, conv_valid_in, conv_chan_in, conv_code_in} = '0;
    {reg_rd_in, reg_wr_in, reg_addr_in, reg_wdata_in} = '0;
    rst();
    sweep();
    repeat (2000) begin
      r1 = xs();
      r2 = xs();
      drv(r1[0], r1[3:1], r2[15:0], r1[5:4] == 2'b00, r1[6],
          8'h62 + 8'(r1[11:8]), r2[23:16]);
    end
    rst();
    sweep();
    drv(0, 0, 0, 0, 0, 0, 0);
    repeat (2) @(posedge ref_clk_in);
    check(8'(exp_q.size()), 8'h00);
    tally_and_finish();
  end
endmodule // pkh_top_bench
